// *** verilog/slave_sm_consts.svh ***
// Constants for the fieldbus slave state machine link
// How it works
// R1 - Reset puts slave into power-on state
// R2 - Power-on refuses mailbox and process data
// R3 - Master sets channels 0,1 as mailbox
// R4 - Power-on to configuring checks mailbox setup
// R5 - Configuring allows mailbox, blocks process data
// R6 - Master sets process channels from 2
// R7 - Configuring to guarded checks process, clock setup
// R8 - Inputs copied to memory before guarded ack; here they are copied on the same edge that raises the ack
// R9 - Guarded: traffic allowed, inputs refreshed, outputs safe
// R10 - Watchdog forces safe outputs unless disabled
// R11 - Master gives valid outputs before running
// R12 - Running copies outputs, allows all traffic
// R13 - Update state only from power-on
// R14 - Update state allows only file transfer
// R15 - Running is normal resting state
// R16 - Master drives every transition by command
// R17 - Process image holds exactly one bit
// R18 - No address or configuration settings needed
// R19 - Illegal request or failed check: stay, no ack
`ifndef SLAVE_SM_CONSTS_SVH
`define SLAVE_SM_CONSTS_SVH
`define ST_POWER_ON    5'h01
`define ST_CONFIGURING 5'h02
`define ST_GUARDED     5'h04
`define ST_RUNNING     5'h08
`define ST_UPDATE      5'h10
`define SAFE_OUTPUT    1'h0
`define MBX_CH_FIRST   2'h0
`define MBX_CH_LAST    2'h1
`define PD_CH_FIRST    2'h2
`endif

// *** verilog/slave_sm_pkg.sv ***
// Types shared by both ends of the state link
`include "slave_sm_consts.svh"
package slave_sm_pkg;
  typedef enum logic [4:0] {
    power_on    = `ST_POWER_ON,
    configuring = `ST_CONFIGURING,
    guarded     = `ST_GUARDED,
    running     = `ST_RUNNING,
    update      = `ST_UPDATE
  } slave_state_t;
  typedef enum logic [1:0] {
    mbx_plain = 2'h0,
    mbx_file  = 2'h1
  } mbx_kind_t;
endpackage : slave_sm_pkg

// *** verilog/slave_link_if.sv ***
// Link between fieldbus master and slave state machine
`timescale 1ns/1ps
interface slave_link_if;
  slave_sm_pkg::slave_state_t req_state;
  logic                       req_valid;
  logic                       ack;
  logic                       nak;
  slave_sm_pkg::slave_state_t cur_state;
  logic                       mbx_valid;
  slave_sm_pkg::mbx_kind_t    mbx_kind;
  logic                       mbx_accept;
  logic                       mbx_refuse;
  logic                       pd_valid;
  logic                       pd_out;
  logic                       pd_accept;
  logic                       pd_refuse;
  logic                       pd_in;
  logic [1:0]                 mbx_ch_cfg;
  logic [1:0]                 pd_ch_start;
  logic                       pd_cfg_ok;
  logic                       dc_used;
  logic                       dc_cfg_ok;
  modport slave (input req_state, req_valid, mbx_valid, mbx_kind, pd_valid, pd_out,
                 mbx_ch_cfg, pd_ch_start, pd_cfg_ok, dc_used, dc_cfg_ok,
                 output ack, nak, cur_state, mbx_accept, mbx_refuse, pd_accept,
                 pd_refuse, pd_in);
  modport master (output req_state, req_valid, mbx_valid, mbx_kind, pd_valid, pd_out,
                  mbx_ch_cfg, pd_ch_start, pd_cfg_ok, dc_used, dc_cfg_ok,
                  input ack, nak, cur_state, mbx_accept, mbx_refuse, pd_accept,
                  pd_refuse, pd_in);
endinterface : slave_link_if

// *** verilog/slave_state_machine.sv ***
// Slave end: state machine, traffic gating, process image
`timescale 1ns/1ps
`include "slave_sm_consts.svh"
module slave_state_machine (
  input  wire logic   core_clk,
  input  wire logic   resetn,
  slave_link_if.slave link,
  input  wire logic   field_in,
  input  wire logic   watchdog_off,
  output logic        field_out,
  output logic        mem_in
);
  slave_sm_pkg::slave_state_t state;
  logic                       pending;
  logic                       pending_to_guarded;

  // Requested move is a legal edge of the graph
  function automatic logic legal_move(input slave_sm_pkg::slave_state_t from,
                                      input slave_sm_pkg::slave_state_t to);
    logic ok;
    ok = 1'b0;
    case (from)
      slave_sm_pkg::power_on:    ok = (to == slave_sm_pkg::configuring) ||
                                      (to == slave_sm_pkg::update);     // [R13]
      slave_sm_pkg::configuring: ok = (to == slave_sm_pkg::guarded) ||
                                      (to == slave_sm_pkg::power_on);
      slave_sm_pkg::guarded:     ok = (to == slave_sm_pkg::running) ||
                                      (to == slave_sm_pkg::configuring) ||
                                      (to == slave_sm_pkg::power_on);
      slave_sm_pkg::running:     ok = (to != slave_sm_pkg::update);
      slave_sm_pkg::update:      ok = (to == slave_sm_pkg::power_on);
      default:                   ok = 1'b0;
    endcase
    return ok;
  endfunction : legal_move

  logic check_ok;
  always_comb begin
    check_ok = 1'b1;
    if (state == slave_sm_pkg::power_on && link.req_state == slave_sm_pkg::configuring)
      check_ok = (link.mbx_ch_cfg == ((2'h1 << `MBX_CH_FIRST) | (2'h1 << `MBX_CH_LAST)));  // [R4]
    if (state == slave_sm_pkg::configuring && link.req_state == slave_sm_pkg::guarded)
      check_ok = link.pd_cfg_ok && (link.pd_ch_start == `PD_CH_FIRST) &&
                 (!link.dc_used || link.dc_cfg_ok);  // [R7]
  end

  // State register; a refused request leaves it alone
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state <= slave_sm_pkg::power_on;  // [R1]
    end else if (link.req_valid && legal_move(state, link.req_state) && check_ok) begin
      state <= link.req_state;  // [R16] [R15]
    end
  end

  // Ack of every accepted move one cycle late, so on guarded entry inputs land in memory on the same edge
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      link.ack           <= 1'b0;
      link.nak           <= 1'b0;
      pending            <= 1'b0;
      pending_to_guarded <= 1'b0;
    end else begin
      pending            <= link.req_valid && legal_move(state, link.req_state) && check_ok;
      pending_to_guarded <= link.req_valid && link.req_state == slave_sm_pkg::guarded;
      link.ack           <= pending;  // [R8]
      link.nak           <= link.req_valid &&
                            !(legal_move(state, link.req_state) && check_ok);  // [R19]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      link.cur_state <= slave_sm_pkg::power_on;
    end else begin
      link.cur_state <= state;
    end
  end

  // Traffic gating by state
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      link.mbx_accept <= 1'b0;
      link.mbx_refuse <= 1'b0;
      link.pd_accept  <= 1'b0;
      link.pd_refuse  <= 1'b0;
    end else begin
      case (state)
        slave_sm_pkg::power_on: begin
          link.mbx_accept <= 1'b0;  // [R2]
          link.mbx_refuse <= link.mbx_valid;
          link.pd_accept  <= 1'b0;
          link.pd_refuse  <= link.pd_valid;
        end
        slave_sm_pkg::configuring: begin
          link.mbx_accept <= link.mbx_valid;  // [R5]
          link.mbx_refuse <= 1'b0;
          link.pd_accept  <= 1'b0;
          link.pd_refuse  <= link.pd_valid;
        end
        slave_sm_pkg::guarded, slave_sm_pkg::running: begin
          link.mbx_accept <= link.mbx_valid;  // [R9] [R12]
          link.mbx_refuse <= 1'b0;
          link.pd_accept  <= link.pd_valid;
          link.pd_refuse  <= 1'b0;
        end
        slave_sm_pkg::update: begin
          link.mbx_accept <= link.mbx_valid && link.mbx_kind == slave_sm_pkg::mbx_file;  // [R14]
          link.mbx_refuse <= link.mbx_valid && link.mbx_kind != slave_sm_pkg::mbx_file;
          link.pd_accept  <= 1'b0;
          link.pd_refuse  <= link.pd_valid;
        end
        default: begin
          link.mbx_accept <= 1'b0;
          link.mbx_refuse <= link.mbx_valid;
          link.pd_accept  <= 1'b0;
          link.pd_refuse  <= link.pd_valid;
        end
      endcase
    end
  end

  // One-bit image each way; fixed mapping, nothing to set up [R17] [R18]
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mem_in      <= 1'b0;
      link.pd_in  <= 1'b0;
    end else if (state == slave_sm_pkg::guarded || state == slave_sm_pkg::running ||
                 pending_to_guarded) begin
      mem_in      <= field_in;  // [R8] [R9]
      link.pd_in  <= field_in;
    end
  end

  // Output stage: safe unless running, or watchdog off in guarded
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      field_out <= `SAFE_OUTPUT;
    end else if (link.pd_valid && (state == slave_sm_pkg::running ||
                 (state == slave_sm_pkg::guarded && watchdog_off))) begin
      field_out <= link.pd_out;  // [R12] [R10]
    end else if (!(state == slave_sm_pkg::running ||
                 (state == slave_sm_pkg::guarded && watchdog_off))) begin
      field_out <= `SAFE_OUTPUT;  // [R9] [R10]
    end
  end
endmodule : slave_state_machine

// *** verilog/fieldbus_master_end.sv ***
// Master end: walks the slave up to running by command
`timescale 1ns/1ps
`include "slave_sm_consts.svh"
module fieldbus_master_end (
  input  wire logic    core_clk,
  input  wire logic    resetn,
  slave_link_if.master link,
  input  wire logic    start,
  input  wire logic    boot_req,
  input  wire logic    out_bit,
  input  wire logic    use_dc,
  output logic         busy,
  output logic         at_running,
  output logic         failed,
  output logic         in_bit
);
  typedef enum logic [3:0] {
    m_idle = 4'h1,
    m_send = 4'h2,
    m_wait = 4'h4,
    m_done = 4'h8
  } mstate_t;
  mstate_t                    ms;
  slave_sm_pkg::slave_state_t target;

  function automatic slave_sm_pkg::slave_state_t next_step(
      input slave_sm_pkg::slave_state_t s);
    case (s)
      slave_sm_pkg::power_on:    return slave_sm_pkg::configuring;
      slave_sm_pkg::configuring: return slave_sm_pkg::guarded;
      default:                   return slave_sm_pkg::running;
    endcase
  endfunction : next_step

  // Channel setup held constant; mailbox on 0 and 1, process from 2
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      link.mbx_ch_cfg  <= 2'h0;
      link.pd_ch_start <= 2'h0;
      link.pd_cfg_ok   <= 1'b0;
      link.dc_used     <= 1'b0;
      link.dc_cfg_ok   <= 1'b0;
    end else begin
      link.mbx_ch_cfg  <= 2'h3;         // [R3]
      link.pd_ch_start <= `PD_CH_FIRST; // [R6]
      link.pd_cfg_ok   <= 1'b1;
      link.dc_used     <= use_dc;
      link.dc_cfg_ok   <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ms             <= m_idle;
      target         <= slave_sm_pkg::power_on;
      link.req_valid <= 1'b0;
      link.req_state <= slave_sm_pkg::power_on;
      failed         <= 1'b0;
    end else begin
      case (ms)
        m_idle: if (start || boot_req) begin
          target <= boot_req ? slave_sm_pkg::update : slave_sm_pkg::running;
          failed <= 1'b0;
          ms     <= m_send;
        end
        m_send: begin
          link.req_valid <= 1'b1;  // [R16]
          link.req_state <= (target == slave_sm_pkg::update) ? slave_sm_pkg::update
                                                             : next_step(link.cur_state);
          ms             <= m_wait;
        end
        m_wait: begin
          link.req_valid <= 1'b0;
          if (link.nak) begin
            failed <= 1'b1;
            ms     <= m_done;
          end else if (link.ack) begin
            ms <= (link.req_state == target) ? m_done : m_send;
          end
        end
        m_done: ms <= m_idle;
        default: ms <= m_idle;
      endcase
    end
  end

  // Outputs sent every cycle, so valid data precede the running request
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      link.pd_valid  <= 1'b0;
      link.pd_out    <= 1'b0;
      link.mbx_valid <= 1'b0;
      link.mbx_kind  <= slave_sm_pkg::mbx_plain;
      in_bit         <= 1'b0;
      busy           <= 1'b0;
      at_running     <= 1'b0;
    end else begin
      link.pd_valid  <= 1'b1;     // [R11]
      link.pd_out    <= out_bit;
      link.mbx_valid <= 1'b0;
      link.mbx_kind  <= slave_sm_pkg::mbx_plain;
      in_bit         <= link.pd_in;
      busy           <= (ms != m_idle);
      at_running     <= (link.cur_state == slave_sm_pkg::running);
    end
  end
endmodule : fieldbus_master_end

// *** testbench/slave_link_asserts.sv ***
// Assertions on the master-slave state link
`timescale 1ns/1ps
module slave_link_asserts (
  input wire logic                       core_clk,
  input wire logic                       resetn,
  input wire slave_sm_pkg::slave_state_t req_state,
  input wire logic                       req_valid,
  input wire logic                       ack,
  input wire logic                       nak,
  input wire slave_sm_pkg::slave_state_t cur_state,
  input wire logic                       pd_valid,
  input wire logic                       pd_accept,
  input wire logic                       pd_refuse,
  input wire logic [1:0]                 mbx_ch_cfg,
  input wire logic [1:0]                 pd_ch_start,
  input wire logic                       pd_cfg_ok,
  input wire logic                       dc_used,
  input wire logic                       dc_cfg_ok
);
  logic req_d;
  // Gating follows the inner state, which leads cur_state by one cycle
  always_ff @(posedge core_clk) req_d <= req_valid;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire on_cfg = req_valid && cur_state == slave_sm_pkg::power_on
                && req_state == slave_sm_pkg::configuring;
  wire cfg_gd = req_valid && cur_state == slave_sm_pkg::configuring
                && req_state == slave_sm_pkg::guarded;
  wire gd_ok = pd_cfg_ok && pd_ch_start == 2'h2 && (!dc_used || dc_cfg_ok);
  wire pd_q = pd_valid && !req_d;
  reset_state_a: assert property ($rose(resetn) |-> cur_state == slave_sm_pkg::power_on)
    else $error("state not power-on after reset");
  pd_power_on_a: assert property (pd_q && cur_state == slave_sm_pkg::power_on
    |=> pd_refuse && !pd_accept) else $error("process data taken in power-on");
  pd_config_a: assert property (pd_q && cur_state == slave_sm_pkg::configuring
    |=> pd_refuse && !pd_accept) else $error("process data taken in configuring");
  pd_open_a: assert property (pd_q && cur_state inside {slave_sm_pkg::guarded,
    slave_sm_pkg::running} |=> pd_accept && !pd_refuse) else $error("process data refused");
  mbx_check_a: assert property (on_cfg && mbx_ch_cfg != 2'h3 |=> nak)
    else $error("bad mailbox setup accepted");
  pd_check_a: assert property (cfg_gd && !gd_ok |=> nak ##1
    cur_state == slave_sm_pkg::configuring) else $error("bad process setup accepted");
  ack_timing_a: assert property (on_cfg && mbx_ch_cfg == 2'h3 |=> !nak ##1
    (ack && cur_state == slave_sm_pkg::configuring)) else $error("legal move not acked");
  update_from_on_a: assert property (req_valid && req_state == slave_sm_pkg::update
    && cur_state != slave_sm_pkg::power_on |=> nak) else $error("update entered wrongly");
  state_by_cmd_a: assert property ($changed(cur_state) |-> $past(req_valid, 2))
    else $error("state moved without request");
  cover property (on_cfg ##2 ack);
  cover property (req_valid && req_state == slave_sm_pkg::running ##2 ack);
  cover property (pd_accept && cur_state == slave_sm_pkg::running);
endmodule : slave_link_asserts

// *** testbench/fieldbus_slave_state_machine_tb.sv ***
// Self-checking bench for both ends of the state link
`timescale 1ns/1ps
module fieldbus_slave_state_machine_tb;
  typedef struct {
    logic [4:0] rq, st;
    logic [1:0] cfg, ps;
    logic       dco, wd, ok, fo;
    logic [2:0] acc;
  } row_t;
  logic core_clk = 1'b0, resetn = 1'b0, start = 1'b0, boot_req = 1'b0, out_bit = 1'b0;
  logic field_in = 1'b0, field_in2 = 1'b0, wd_off2 = 1'b0;
  logic busy, at_running, failed, in_bit, field_out, mem_in, field_out2, mem_in2, sa, sr;
  int   errors = 0, num_checks = 0, cycles = 0, n;
  row_t rows [15];
  slave_link_if link ();
  slave_link_if link2 ();
  fieldbus_master_end fieldbus_master_end_inst (.core_clk(core_clk), .resetn(resetn),
    .link(link.master), .start(start), .boot_req(boot_req), .out_bit(out_bit), .use_dc(1'b1),
    .busy(busy), .at_running(at_running), .failed(failed), .in_bit(in_bit));
  slave_state_machine slave_state_machine_inst (.core_clk(core_clk), .resetn(resetn),
    .link(link.slave), .field_in(field_in), .watchdog_off(1'b0), .field_out(field_out),
    .mem_in(mem_in));
  // Second slave faces the bench so that refusals can be provoked
  slave_state_machine slave_state_machine_inst_b (.core_clk(core_clk), .resetn(resetn),
    .link(link2.slave), .field_in(field_in2), .watchdog_off(wd_off2),
    .field_out(field_out2), .mem_in(mem_in2));
  slave_link_asserts slave_link_asserts_inst (.core_clk(core_clk), .resetn(resetn),
    .req_state(link.req_state), .req_valid(link.req_valid), .ack(link.ack), .nak(link.nak),
    .cur_state(link.cur_state), .pd_valid(link.pd_valid), .pd_accept(link.pd_accept),
    .pd_refuse(link.pd_refuse), .mbx_ch_cfg(link.mbx_ch_cfg), .pd_ch_start(link.pd_ch_start),
    .pd_cfg_ok(link.pd_cfg_ok), .dc_used(link.dc_used), .dc_cfg_ok(link.dc_cfg_ok));
  always #2 core_clk = ~core_clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic req(input logic [4:0] s, input logic ok);
    link2.req_state = slave_sm_pkg::slave_state_t'(s);
    link2.req_valid = 1'b1;
    @(posedge core_clk) #1;
    link2.req_valid = 1'b0;
    for (n = 0; n < 4 && !(link2.ack || link2.nak); n++) @(posedge core_clk) #1;
    check({link2.ack, link2.nak}, {ok, !ok});
  endtask : req
  task automatic traffic(input logic pd, input slave_sm_pkg::mbx_kind_t k, input logic ok);
    link2.mbx_kind = k;
    if (pd) link2.pd_valid = 1'b1;
    else link2.mbx_valid = 1'b1;
    @(posedge core_clk) #1;
    sa = pd ? link2.pd_accept : link2.mbx_accept;
    sr = pd ? link2.pd_refuse : link2.mbx_refuse;
    {link2.pd_valid, link2.mbx_valid} = 2'h0;
    check({sa, sr}, {ok, !ok});
    // Answer pulses last one cycle only
    @(posedge core_clk) #1;
    check({link2.pd_accept, link2.pd_refuse, link2.mbx_accept, link2.mbx_refuse}, 4'h0);
  endtask : traffic
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  // Ceiling well above the roughly 200 cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      $display("Error at %0t: timeout", $time);
      complete_run();
    end
  end
  initial begin
    {link2.req_valid, link2.mbx_valid, link2.pd_valid} = 3'h0;
    link2.req_state = slave_sm_pkg::power_on;
    link2.mbx_kind = slave_sm_pkg::mbx_plain;
    {link2.pd_out, link2.pd_cfg_ok, link2.dc_used, link2.dc_cfg_ok} = 4'hf;
    link2.mbx_ch_cfg = 2'h3;
    link2.pd_ch_start = 2'h2;
    rows = '{'{5'h08, 5'h01, 2'h3, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0},
      '{5'h02, 5'h01, 2'h1, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0},
      '{5'h10, 5'h10, 2'h3, 2'h2, 1'b1, 1'b0, 1'b1, 1'b0, 3'h2},
      '{5'h02, 5'h10, 2'h3, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 3'h2},
      '{5'h01, 5'h01, 2'h3, 2'h2, 1'b1, 1'b0, 1'b1, 1'b0, 3'h0},
      '{5'h02, 5'h02, 2'h3, 2'h2, 1'b1, 1'b0, 1'b1, 1'b0, 3'h6},
      '{5'h10, 5'h02, 2'h3, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 3'h6},
      '{5'h04, 5'h02, 2'h3, 2'h1, 1'b1, 1'b0, 1'b0, 1'b0, 3'h6},
      '{5'h04, 5'h02, 2'h3, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0, 3'h6},
      '{5'h04, 5'h04, 2'h3, 2'h2, 1'b1, 1'b0, 1'b1, 1'b0, 3'h7},
      '{5'h08, 5'h08, 2'h3, 2'h2, 1'b1, 1'b0, 1'b1, 1'b1, 3'h7},
      '{5'h10, 5'h08, 2'h3, 2'h2, 1'b1, 1'b0, 1'b0, 1'b1, 3'h7},
      '{5'h04, 5'h04, 2'h3, 2'h2, 1'b1, 1'b1, 1'b1, 1'b1, 3'h7},
      '{5'h10, 5'h04, 2'h3, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 3'h7},
      '{5'h01, 5'h01, 2'h3, 2'h2, 1'b1, 1'b1, 1'b1, 1'b0, 3'h0}};
    repeat (16) @(posedge core_clk);
    #1 resetn = 1'b1;
    check(link2.cur_state, 5'h01);
    foreach (rows[i]) begin
      link2.mbx_ch_cfg = rows[i].cfg;
      link2.pd_ch_start = rows[i].ps;
      link2.dc_cfg_ok = rows[i].dco;
      wd_off2 = rows[i].wd;
      field_in2 = i[0];
      req(rows[i].rq, rows[i].ok);
      if (rows[i].ok && rows[i].st == 5'h04) check(mem_in2, field_in2);
      check(link2.cur_state, rows[i].st);
      traffic(1'b0, slave_sm_pkg::mbx_plain, rows[i].acc[2]);
      traffic(1'b0, slave_sm_pkg::mbx_file, rows[i].acc[1]);
      traffic(1'b1, slave_sm_pkg::mbx_plain, rows[i].acc[0]);
      check(field_out2, rows[i].fo);
    end
    $display("Test state table done");
    start = 1'b1;
    @(posedge core_clk) #1 start = 1'b0;
    @(posedge core_clk) #1;
    check(busy, 1'b1);
    for (n = 0; n < 200 && at_running !== 1'b1; n++) @(posedge core_clk) #1;
    check({at_running, failed, link.cur_state}, {2'h2, 5'h08});
    for (int v = 0; v < 4; v++) begin
      {out_bit, field_in} = v[1:0];
      repeat (4) @(posedge core_clk) #1;
      check({field_out, in_bit}, v[1:0]);
    end
    // Update asked from running must be refused and flagged
    boot_req = 1'b1;
    @(posedge core_clk) #1 boot_req = 1'b0;
    repeat (6) @(posedge core_clk) #1;
    check({failed, busy, link.cur_state}, {2'h2, 5'h08});
    $display("Test master walk done");
    resetn = 1'b0;
    repeat (3) @(posedge core_clk) #1;
    check({link.cur_state, link2.cur_state, field_out, failed, busy},
          {5'h01, 5'h01, 3'h0});
    resetn = 1'b1;
    boot_req = 1'b1;
    @(posedge core_clk) #1 boot_req = 1'b0;
    for (n = 0; n < 50 && link.cur_state !== 5'h10; n++) @(posedge core_clk) #1;
    check({failed, link.cur_state}, {1'b0, 5'h10});
    $display("Test reset and update done");
    complete_run();
  end
endmodule : fieldbus_slave_state_machine_tb
